// ---- common/print_seq_map.vh ----
`ifndef PRINT_SEQ_MAP_VH
`define PRINT_SEQ_MAP_VH
// row positions within a card cycle, sensed 9 edge first
`define ROW_9        4'h9
`define ROW_8        4'h8
`define ROW_4        4'h4
`define ROW_3        4'h3
`define ROW_2        4'h2
`define ROW_1        4'h1
`define ROW_0        4'h0
`define ROW_11       4'hB
`define ROW_12       4'hC
// storage capacity for the third line
`define STORE_COLS   24
`define STORE_GROUPS 6
// line index codes
`define LINE_IDLE    2'h0
`define LINE_ONE     2'h1
`define LINE_TWO     2'h2
`define LINE_THREE   2'h3
`endif

// ---- hdl/multi_line_print_sequencer.v ----
`timescale 1ns/1ns
// What this block does
// [RULE_01] single line zones at one station, numerics from the next station print it
// [RULE_02] first line: zones from station one, numerics from station two
// [RULE_03] second line: zones from station two, numerics from station three
// [RULE_04] third line: zones and numerics at station three, numerics stored one cycle
// [RULE_05] at fourth position stored numerics read out and printed with zones; zone exits stay low then, third line zones exit in the store cycle
// [RULE_06] storage clears to zero as third line prints; must start at zero
// [RULE_07] third line storage holds 24 columns in six counter groups
// [RULE_08] station three numeric rows sensed before zone rows
// [RULE_09] feeding of following cards suspended while lines two and three print
// [RULE_10] following card halted between rows 1 and 0 until printing done
// [RULE_11] control field comparison of stations one and two still allowed when held
// [RULE_12] station one control column is wired to the line control input
// [RULE_13] zone and numeric impulses pass through separate selectors to their exits
// [RULE_14] card is line controlled only with 9 and 8 in one column
// [RULE_15] extra 1, 2 or 3 punch sets line count and selector stepping
// [RULE_16] 9-8-4 acts as one line card without the idle feed cycle
// [RULE_17] line index tracks active line and returns idle after last line
`include "print_seq_map.vh"
module multi_line_print_sequencer #(
   parameter COLS = `STORE_COLS
) (
   // clock and reset
   input  wire            clk_sys_i,
   input  wire            rstn_i,
   // machine timing, same clock domain
   input  wire            cycle_start_i,
   input  wire            row_strobe_i,
   input  wire [3:0]      row_i,
   // line control column from station one
   input  wire            line_control_input_i,
   // per-line entries, one bit per column
   input  wire [COLS-1:0] zone_entry1_i,
   input  wire [COLS-1:0] zone_entry2_i,
   input  wire [COLS-1:0] zone_entry3_i,
   input  wire [COLS-1:0] print_entry1_i,
   input  wire [COLS-1:0] print_entry2_i,
   input  wire [COLS-1:0] print_entry3_i,
   // control field sensed at stations one and two
   input  wire [COLS-1:0] ctrl_field1_i,
   input  wire [COLS-1:0] ctrl_field2_i,
   // selector exits
   output reg  [COLS-1:0] zone_exit_o,
   output reg  [COLS-1:0] print_exit_o,
   // feed and status
   output wire            feed_hold_o,
   output reg             idle_feed_o,
   output reg             compare_equal_o,
   output reg  [1:0]      line_index_o,
   output wire            store_empty_o
);
   localparam S_IDLE = 5'h01;
   localparam S_L1   = 5'h02;
   localparam S_L2   = 5'h04;
   localparam S_L3   = 5'h08;
   localparam S_L4   = 5'h10;

   reg [4:0]      state_q;
   reg [4:0]      state_d;
   reg            saw9_q;
   reg            saw8_q;
   reg [1:0]      count_q;
   reg            four_q;
   reg [1:0]      lines_q;
   reg            only_one_q;
   reg [3:0]      digit_q [0:COLS-1];
   reg            held_q;

   wire zone_row = (row_i == `ROW_0) || (row_i == `ROW_11) || (row_i == `ROW_12);
   wire in_mlp   = (state_q != S_IDLE);
   wire card_ok  = saw9_q && saw8_q && (count_q != 2'h0 || four_q); // see [RULE_14]

   // control column decode, sampled during the read at station one
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         saw9_q  <= 1'b0;
         saw8_q  <= 1'b0;
         count_q <= 2'h0;
         four_q  <= 1'b0;
      end else if (cycle_start_i) begin
         saw9_q  <= 1'b0;
         saw8_q  <= 1'b0;
         count_q <= 2'h0;
         four_q  <= 1'b0;
      end else if (row_strobe_i && line_control_input_i) begin // see [RULE_12]
         if (row_i == `ROW_9) saw9_q <= 1'b1;
         if (row_i == `ROW_8) saw8_q <= 1'b1;
         if (row_i == `ROW_4) four_q <= 1'b1; // see [RULE_16]
         // a later count punch overrides an earlier one
         if (row_i == `ROW_1) count_q <= 2'h1; // see [RULE_15]
         if (row_i == `ROW_2) count_q <= 2'h2;
         if (row_i == `ROW_3) count_q <= 2'h3;
      end
   end

   // line index steps once per card cycle
   // a card seen while lines are still owed is dropped; the feed hold keeps one from arriving
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE:  if (card_ok) state_d = S_L1;
         S_L1:    state_d = (lines_q == `LINE_ONE) ? S_IDLE : S_L2;
         S_L2:    state_d = (lines_q == `LINE_TWO) ? S_IDLE : S_L3;
         S_L3:    state_d = S_L4;
         S_L4:    state_d = S_IDLE; // see [RULE_17]
         default: state_d = S_IDLE;
      endcase
   end

   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q    <= S_IDLE;
         lines_q    <= `LINE_IDLE;
         only_one_q <= 1'b0;
         idle_feed_o <= 1'b0;
      end else if (cycle_start_i) begin
         state_q <= state_d;
         if (state_q == S_IDLE && card_ok) begin
            lines_q    <= four_q ? `LINE_ONE : count_q;
            only_one_q <= ~four_q && (count_q == `LINE_ONE);
         end
         // one line card punched 1 (not 9-8-4) followed by a normal card costs an idle cycle
         idle_feed_o <= (state_q == S_L1) && only_one_q && !card_ok; // see [RULE_16]
      end
   end

   // index register follows the state at the same edge, so the output comes from a flop
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         line_index_o <= `LINE_IDLE;
      end else if (cycle_start_i) begin
         case (state_d)
            S_L1:    line_index_o <= `LINE_ONE;
            S_L2:    line_index_o <= `LINE_TWO;
            S_L3,
            S_L4:    line_index_o <= `LINE_THREE;
            default: line_index_o <= `LINE_IDLE;
         endcase
      end
   end

   // feed hold only while lines two and three are still owed
   assign feed_hold_o = held_q; // see [RULE_09]
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         held_q <= 1'b0;
      // set wins over the cycle start clear, so a row 1 strobe on that edge is not lost
      end else if (row_strobe_i && row_i == `ROW_1 && in_mlp
                   && state_d != S_IDLE && state_q != S_L4) begin
         held_q <= 1'b1; // see [RULE_10]
      end else if (cycle_start_i) begin
         held_q <= 1'b0;
      end
   end

   // comparison keeps running during the hold
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) compare_equal_o <= 1'b0;
      else compare_equal_o <= (ctrl_field1_i == ctrl_field2_i); // see [RULE_11]
   end

   // zone and print selectors, one per column
   genvar c;
   generate
      for (c = 0; c < COLS; c = c + 1) begin : g_col
         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               zone_exit_o[c]  <= 1'b0;
               print_exit_o[c] <= 1'b0;
               digit_q[c]      <= 4'h0;
            end else begin
               zone_exit_o[c]  <= 1'b0;
               print_exit_o[c] <= 1'b0;
               if (row_strobe_i) begin
                  // numeric rows land first, zone rows later
                  if (zone_row) begin // see [RULE_08]
                     case (state_q)
                        S_L1:    zone_exit_o[c] <= zone_entry1_i[c]; // see [RULE_01] [RULE_02] [RULE_13]
                        S_L2:    zone_exit_o[c] <= zone_entry2_i[c]; // see [RULE_03]
                        S_L3:    zone_exit_o[c] <= zone_entry3_i[c]; // see [RULE_04]
                        default: zone_exit_o[c] <= 1'b0;
                     endcase
                  end else begin
                     case (state_q)
                        S_L1:    print_exit_o[c] <= print_entry1_i[c]; // see [RULE_02] [RULE_13]
                        S_L2:    print_exit_o[c] <= print_entry2_i[c]; // see [RULE_03]
                        S_L3:    if (print_entry3_i[c]) digit_q[c] <= row_i; // see [RULE_04] [RULE_07]
                        // a 0 punch is a zone row, so a stored zero means no digit
                        S_L4:    print_exit_o[c] <= (digit_q[c] == row_i) && (digit_q[c] != 4'h0); // see [RULE_05]
                        default: print_exit_o[c] <= 1'b0;
                     endcase
                  end
               end
               // storage counters reset as the third line prints
               if (cycle_start_i && state_q == S_L4) digit_q[c] <= 4'h0; // see [RULE_06]
            end
         end
      end
   endgenerate

   // storage must be clear before a new third line uses it, watched per counter group
   // COLS should be a multiple of the group count, or the last columns go unwatched
   localparam GROUPS    = `STORE_GROUPS;
   localparam PER_GROUP = COLS / GROUPS; // see [RULE_07]
   wire [GROUPS-1:0] group_used;
   genvar g;
   generate
      for (g = 0; g < GROUPS; g = g + 1) begin : g_grp
         reg     used;
         integer j;
         always @* begin
            used = 1'b0;
            for (j = 0; j < PER_GROUP; j = j + 1) begin
               used = used | (digit_q[g * PER_GROUP + j] != 4'h0);
            end
         end
         assign group_used[g] = used;
      end
   endgenerate
   assign store_empty_o = ~|group_used; // see [RULE_06]
endmodule

// ---- verif/card_reader.sv ----
`timescale 1ns/1ns
module card_reader (
   input  wire       clk_i,
   input  wire       go_i,
   input  wire [3:0] code_i,
   output reg        start_o = 1'b0,
   output reg        strobe_o = 1'b0,
   output reg  [3:0] row_o = 4'h0,
   output reg        ctl_o = 1'b0,
   output reg        busy_o = 1'b0
);
   reg  [4:0] k_q = 5'h00;
   wire [3:0] idx = k_q[4:1];
   // 9 edge first, zone rows last; strobe a clock after the row settles
   wire [3:0] row_d = idx < 4'h9 ? 4'h9 - idx : idx == 4'h9 ? 4'h0 : idx == 4'hA ? 4'hB : 4'hC;
   always @(posedge clk_i) begin
      start_o  <= go_i;
      strobe_o <= busy_o & k_q[0];
      // released row lines toggle so stale values never look valid
      row_o    <= busy_o ? row_d : ~row_o;
      ctl_o    <= busy_o && code_i != 4'h0 && (row_d == 4'h9 || row_d == 4'h8 || row_d == code_i);
      k_q      <= go_i ? 5'h00 : k_q + {4'h0, busy_o};
      busy_o   <= go_i | (busy_o & k_q != 5'h17);
   end
endmodule

// ---- verif/print_seq_properties.sv ----
`timescale 1ns/1ns
module print_seq_checker #(
   parameter COLS = 24
) (
   input wire            clk_sys_i, rstn_i, cycle_start_i, row_strobe_i, line_control_input_i,
   input wire [3:0]      row_i,
   input wire            feed_hold_o, idle_feed_o, compare_equal_o, store_empty_o,
   input wire [1:0]      line_index_o,
   input wire [COLS-1:0] zone_entry1_i, zone_entry2_i, zone_entry3_i, print_entry1_i, print_entry2_i,
   input wire [COLS-1:0] ctrl_field1_i, ctrl_field2_i, zone_exit_o, print_exit_o
);
   reg  s9_q, s8_q, sn_q;
   wire hit  = row_strobe_i & line_control_input_i;
   wire zr   = row_i == 4'h0 || row_i > 4'h9;
   wire nr   = row_strobe_i && !zr;
   wire mark = s9_q & s8_q & sn_q;
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) {s9_q, s8_q, sn_q} <= 3'h0;
      else if (cycle_start_i) {s9_q, s8_q, sn_q} <= 3'h0;
      else if (hit) begin
         {s9_q, s8_q} <= {s9_q | row_i == 4'h9, s8_q | row_i == 4'h8};
         sn_q <= sn_q | (row_i > 4'h0 && row_i < 4'h5);
      end
   end
   // the store cycle is the first index 3 cycle after index 2, the readout cycle the second
   reg  [1:0] prev_idx_q;
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) prev_idx_q <= 2'h0;
      else if (cycle_start_i) prev_idx_q <= line_index_o;
   end
   wire third = line_index_o == 2'h3 && prev_idx_q == 2'h2;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   AST_ENTER_LINE1:
   assert property (cycle_start_i && line_index_o == 2'h0 && mark |=> line_index_o == 2'h1) else $error("no line one");
   AST_INDEX_STEADY:
   assert property (!cycle_start_i |=> $stable(line_index_o)) else $error("line index moved");
   AST_ZONE_LINE1:
   assert property (row_strobe_i && zr && line_index_o == 2'h1 |=> zone_exit_o == $past(zone_entry1_i)) else $error("zone 1");
   AST_PRINT_LINE1:
   assert property (nr && line_index_o == 2'h1 |=> print_exit_o == $past(print_entry1_i)) else $error("print 1");
   AST_ZONE_LINE2:
   assert property (row_strobe_i && zr && line_index_o == 2'h2 |=> zone_exit_o == $past(zone_entry2_i)) else $error("zone 2");
   AST_PRINT_LINE2:
   assert property (nr && line_index_o == 2'h2 |=> print_exit_o == $past(print_entry2_i)) else $error("print 2");
   AST_ZONE_LINE3:
   assert property (row_strobe_i && zr && third |=> zone_exit_o == $past(zone_entry3_i)) else $error("zone 3");
   AST_STORE_NO_PRINT:
   assert property (nr && third |=> print_exit_o == {COLS{1'b0}}) else $error("line 3 printed early");
   AST_HOLD_KEPT:
   assert property (feed_hold_o && !cycle_start_i |=> feed_hold_o) else $error("hold dropped");
   AST_HOLD_AT_ROW1:
   assert property ($rose(feed_hold_o) |-> $past(row_strobe_i) && $past(row_i) == 4'h1) else $error("hold row");
   AST_COMPARE:
   assert property ($past(rstn_i) |-> compare_equal_o == ($past(ctrl_field1_i) == $past(ctrl_field2_i)))
      else $error("compare wrong");
   AST_STORE_CLEAR:
   assert property ($changed(line_index_o) && line_index_o == 2'h0 |-> store_empty_o) else $error("store kept");
   cover property (cycle_start_i && line_index_o == 2'h3);
   cover property ($rose(feed_hold_o));
   cover property ($rose(idle_feed_o));
endmodule
bind multi_line_print_sequencer print_seq_checker #(.COLS(COLS)) i_print_seq_checker (.*);

// ---- verif/test_multi_line_print_sequencer.sv ----
`timescale 1ns/1ns
module test_multi_line_print_sequencer;
   reg         clk_sys_i = 1'b0, rstn_i = 1'b0, go = 1'b0, p5 = 1'b0, ip = 1'b0;
   reg  [3:0]  code = 4'h0;
   reg  [23:0] zone_entry1_i = 0, zone_entry2_i = 0, zone_entry3_i = 0, pat = 0, got = 0;
   reg  [23:0] print_entry1_i = 0, print_entry2_i = 0, print_entry3_i = 0, ctrl_field1_i = 0, ctrl_field2_i = 0;
   wire        cycle_start_i, row_strobe_i, line_control_input_i, busy;
   wire        feed_hold_o, idle_feed_o, compare_equal_o, store_empty_o;
   wire [3:0]  row_i;
   wire [1:0]  line_index_o;
   wire [23:0] zone_exit_o, print_exit_o;
   integer     err_total = 0, checks_done = 0, seed = 32'h97b4, nh = 0, ni = 0, h0, hi, k;
   reg  [31:0] rnd;
   multi_line_print_sequencer i_multi_line_print_sequencer (.*);
   card_reader i_card_reader (.clk_i(clk_sys_i), .go_i(go), .code_i(code), .start_o(cycle_start_i),
      .strobe_o(row_strobe_i), .row_o(row_i), .ctl_o(line_control_input_i), .busy_o(busy));
   initial forever #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      print_entry3_i <= row_i == 4'h5 ? pat : 24'h000000;
      p5 <= row_strobe_i && row_i == 4'h5 && line_index_o == 2'h3;
      if (p5) got <= print_exit_o;
      nh <= nh + feed_hold_o;
      // count rises only: the level stands into the next card's first cycle
      ni <= ni + (idle_feed_o & ~ip);
      ip <= idle_feed_o;
   end
   function integer nl(input [3:0] c);
      nl = c == 4'h4 ? 1 : c + (c == 4'h3);
   endfunction
   task chk(input string name, input [23:0] exp, input [23:0] act);
      begin
         checks_done = checks_done + 1;
         if (exp !== act) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0s expected %h seen %h", name, exp, act);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task cyc(input [3:0] c, input [1:0] exp);
      integer n;
      begin
         rnd = $random(seed);
         {code, go} <= {c, 1'b1};
         {zone_entry1_i, zone_entry2_i, zone_entry3_i} <= {rnd[23:0], ~rnd[23:0], rnd[31:8]};
         {print_entry1_i, print_entry2_i, ctrl_field1_i} <= {rnd[31:8], rnd[27:4], rnd[23:0]};
         ctrl_field2_i <= rnd[0] ? rnd[23:0] : rnd[31:8];
         @(posedge clk_sys_i);
         go <= 1'b0;
         n = 0;
         @(negedge clk_sys_i);
         while (busy && n < 60) begin
            n = n + 1;
            @(negedge clk_sys_i);
         end
         if (busy) begin
            err_total = err_total + 1;
            summarize;
         end
         chk("line_index", exp, line_index_o);
         chk("compare", ctrl_field1_i == ctrl_field2_i, compare_equal_o);
         @(posedge clk_sys_i);
      end
   endtask
   task card(input [3:0] c);
      integer i;
      begin
         cyc(c, 2'h0);
         for (i = 1; i <= nl(c); i = i + 1) cyc(4'h0, i > 3 ? 2'h3 : i[1:0]);
         cyc(4'h0, 2'h0);
         $display("card %0d done", c);
      end
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(negedge clk_sys_i);
      chk("store_empty", 1'b1, store_empty_o);
      rnd = $random(seed);
      pat = rnd[23:0] | 24'h000001;
      @(posedge clk_sys_i);
      h0 = nh;
      card(4'h3);
      chk("third_line", pat, got);
      chk("hold_seen", 1'b1, nh > h0);
      chk("store_empty", 1'b1, store_empty_o);
      h0 = ni;
      hi = nh;
      card(4'h1);
      chk("idle_feed", 1'b1, ni > h0);
      chk("hold_one_line", 1'b0, nh > hi);
      h0 = ni;
      card(4'h4);
      chk("idle_feed", 1'b0, ni > h0);
      card(4'h2);
      for (k = 0; k < 6; k = k + 1) begin
         rnd = $random(seed);
         card({1'b0, rnd[2:0] % 3'h5});
      end
      summarize;
   end
endmodule
